// file: pkg/lsc_pkg.sv
// package for the serial controller status-clear and transmit-control block
package lsc_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [7:0] OFF_RX_ERROR_CLEAR_LOW = 8'h90;
  localparam logic [7:0] OFF_STATUS_CLEAR_HIGH = 8'h94;
  localparam logic [7:0] OFF_SCHED_COMPARE_LOW = 8'h98;
  localparam logic [7:0] OFF_SCHED_COMPARE_HIGH = 8'h9c;
  localparam logic [7:0] OFF_TRANSMIT_CONTROL_LOW = 8'hd8;
  // ==========================================
  // field positions
  localparam int RXBE_WIDTH = 12;
  localparam int BIT_CLR_TXEF = 13;
  localparam int BIT_CLR_RXFF = 12;
  localparam int BIT_CLR_ROVE = 11;
  localparam int BIT_CLR_FCSE = 10;
  localparam int BIT_CLR_SRF = 9;
  localparam int BIT_CLR_PIE = 8;
  localparam int BIT_CLR_BFE = 7;
  localparam int BIT_CLR_SFE = 6;
  localparam int BIT_SLEC = 7;
  localparam int BIT_SLRT = 6;
  localparam int BIT_FRQ = 5;
  localparam int BIT_TRQ = 4;
  // ==========================================
  // reset values and limits
  localparam logic [7:0] TCTL_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CMP_HIGH_VALUE = 16'h0000;
  localparam logic [3:0] LIN_LEN_MIN = 4'h2;
  localparam logic [3:0] LIN_LEN_MAX = 4'ha;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  // ==========================================
  // operating modes
  typedef enum logic [1:0] {
    MODE_UART_THROUGH = 2'b00,
    MODE_UART_BUFFER = 2'b01,
    MODE_LIN_MASTER = 2'b10,
    MODE_OTHER = 2'b11
  } lsc_mode_type;
  // status flags kept by this block
  typedef struct packed {
    logic [11:0] rx_buffer_error_flags;
    logic tx_buffer_empty_flag;
    logic rx_buffer_full_flag;
    logic rx_overflow_flag;
    logic checksum_error_flag;
    logic scheduler_ready_flag;
    logic prep_incomplete_error;
    logic break_field_error;
    logic sync_field_error;
  } lsc_flags_type;
  // controls seen by the frame engine
  typedef struct packed {
    logic enhanced_checksum_select;
    logic master_direction_select;
    logic first_request_control;
    logic transmit_request;
    logic [3:0] transmit_length;
  } lsc_tctl_type;
endpackage

// file: sim/lsc_chk_assertions.sv
// assertion checker on the top ports of the block
`timescale 1ns/1ps
module lsc_chk (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic [3:0] SEL_I,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic POWER_I,
  input wire logic [1:0] MODE_I,
  input wire logic AUTO_CHECKSUM_I,
  input wire logic [7:0] STATUS_SET_I,
  input wire lsc_pkg::lsc_flags_type FLAGS_O,
  input wire logic FRAME_START_O,
  input wire logic PENDING_O,
  input wire logic ENHANCED_CHECKSUM_O,
  input wire logic RX_DIRECTION_O,
  input wire lsc_pkg::lsc_tctl_type TCTL_O
);
  // ==========================================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_wr(a);
    CYC_I && STB_I && ACK_O && WE_I && SEL_I[1:0] == 2'b11 && ADR_I == a;
  endsequence
  property p_ack;
    s_req |=> ACK_O;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_one;
    ACK_O |=> !ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_cmp_high;
    s_req ##0 (!WE_I && ADR_I == lsc_pkg::OFF_SCHED_COMPARE_HIGH) |=> DAT_O == 32'h00000000;
  endproperty
  a_cmp_high: assert property (p_cmp_high) else $error("compare high not zero");
  property p_power;
    !POWER_I |=> TCTL_O == 8'h00 && !PENDING_O;
  endproperty
  a_power: assert property (p_power) else $error("control kept without power");
  property p_enh;
    ENHANCED_CHECKSUM_O == (TCTL_O.enhanced_checksum_select && AUTO_CHECKSUM_I);
  endproperty
  a_enh: assert property (p_enh) else $error("checksum type wrong");
  property p_dir;
    RX_DIRECTION_O == (TCTL_O.master_direction_select && MODE_I == 2'b10);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_start;
    FRAME_START_O |-> PENDING_O && !TCTL_O.transmit_request;
  endproperty
  a_start: assert property (p_start) else $error("request kept after start");
  property p_clr_srf;
    s_wr(lsc_pkg::OFF_STATUS_CLEAR_HIGH) ##0 (DAT_I[9] && !STATUS_SET_I[3])
      |=> !FLAGS_O.scheduler_ready_flag;
  endproperty
  a_clr_srf: assert property (p_clr_srf) else $error("ready flag kept");
  property p_clr_txef;
    s_wr(lsc_pkg::OFF_STATUS_CLEAR_HIGH) ##0 (DAT_I[13] && !STATUS_SET_I[7])
      |=> !FLAGS_O.tx_buffer_empty_flag;
  endproperty
  a_clr_txef: assert property (p_clr_txef) else $error("empty flag kept");
endmodule

// file: sim/lsc_sched_model.sv
// scheduler and free-running timer model on the far side of the block
`timescale 1ns/1ps
module lsc_sched_model (
  input wire logic clk_i,
  input wire logic run_i,
  output logic event_o,
  output logic [15:0] count_o
);
  // ==========================================
  // timer starts near wrap, so it has wrapped before the scheduled test loads compare
  initial begin
    event_o = 1'b0;
    count_o = 16'hfff0;
  end
  // frozen while run_i is low so the bench knows the loaded count
  always @(posedge clk_i) begin
    if (run_i) begin
      count_o <= count_o + 16'h0001;
    end
  end
  // one-cycle scheduler event, only on command
  task pulse();
    @(posedge clk_i);
    event_o <= 1'b1;
    @(posedge clk_i);
    event_o <= 1'b0;
  endtask
endmodule

// file: sim/tb.sv
// self-checking testbench for the status-clear and transmit-control block
`timescale 1ns/1ps
module tb;
  // ==========================================
  // stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, pwr = 1'b1, run = 1'b1;
  logic acs = 1'b0, sen = 1'b0, afe = 1'b0, ack, fs, pend, enh, rxd, sev;
  logic [1:0] mode = 2'b10;
  logic [3:0] sel = 4'h3;
  logic [7:0] adr = 8'h00, sts = 8'h00, e;
  logic [11:0] rxs = 12'h000;
  logic [15:0] slot = 16'h0100, cnt, wd = 16'h0000;
  logic [31:0] dout, q;
  lsc_pkg::lsc_flags_type flags;
  lsc_pkg::lsc_tctl_type tctl;
  int err_total = 0, n_tests = 0, n, b;
  initial forever #25 clk = ~clk;
  lsc_sched_model u_sch (.clk_i(clk), .run_i(run), .event_o(sev), .count_o(cnt));
  lsc_top DUT (.SYS_CLK_I(clk), .SYS_RST_I(rst), .ADR_I(adr), .DAT_I({16'h0000, wd}),
    .DAT_O(dout), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
    .POWER_I(pwr), .MODE_I(mode), .AUTO_CHECKSUM_I(acs), .SCHED_ENABLE_I(sen),
    .AUTO_FRAME_I(afe), .SCHED_EVENT_I(sev), .FREE_COUNT_I(cnt), .SLOT_LENGTH_I(slot),
    .RX_ERR_SET_I(rxs), .STATUS_SET_I(sts), .FLAGS_O(flags), .FRAME_START_O(fs),
    .PENDING_O(pend), .ENHANCED_CHECKSUM_O(enh), .RX_DIRECTION_O(rxd), .TCTL_O(tctl));
  task complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic wishbone cycle; request held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
    q = dout;
    {cyc, stb} <= 2'b00;
    if (n == 20) begin
      err_total++;
      complete_run();
    end
  endtask
  task wait_fs();
    for (n = 0; n < 10 && fs !== 1'b1; n++) @(posedge clk);
    chk("frame start", 32'(fs), 32'h1);
    if (fs !== 1'b1) complete_run();
  endtask
  // ==========================================
  // scenarios
  task t_reset();
    wb(0, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 0);
    chk("control reset", q, 32'h0);
    wb(0, lsc_pkg::OFF_SCHED_COMPARE_LOW, 0);
    chk("compare reset", q, 32'(lsc_pkg::CMP_RESET));
    wb(0, lsc_pkg::OFF_SCHED_COMPARE_HIGH, 0);
    chk("compare high", q, 32'h0);
    wb(0, 8'he0, 0);
    chk("unmapped", q, lsc_pkg::UNMAPPED_READ);
  endtask
  task t_clear();
    @(posedge clk);
    {rxs, sts} <= 20'hfffff;
    @(posedge clk);
    {rxs, sts} <= 20'h00000;
    @(posedge clk);
    chk("flags set", 32'(flags), 32'h000fffff);
    sel <= 4'h1;
    wb(1, lsc_pkg::OFF_RX_ERROR_CLEAR_LOW, 16'h0fff);
    sel <= 4'h3;
    @(posedge clk);
    chk("narrow write", 32'(flags), 32'h000fffff);
    wb(1, lsc_pkg::OFF_RX_ERROR_CLEAR_LOW, 16'h0555);
    @(posedge clk);
    chk("rx clear", 32'(flags.rx_buffer_error_flags), 32'h0aaa);
    e = 8'hff;
    for (b = 6; b < 14; b++) begin
      wb(1, lsc_pkg::OFF_STATUS_CLEAR_HIGH, 16'h0001 << b);
      e[b-6] = 1'b0;
      @(posedge clk);
      chk("status clear", 32'(flags[7:0]), 32'(e));
    end
  endtask
  task t_tctl();
    acs <= 1'b1;
    wb(1, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 16'h00c5);
    wb(0, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 0);
    chk("control", q, 32'h00c5);
    chk("enhanced", 32'(enh), 32'h1);
    chk("rx dir", 32'(rxd), 32'h1);
    {acs, mode} <= 3'b001;
    @(posedge clk);
    chk("enhanced off", 32'(enh), 32'h0);
    chk("rx dir off", 32'(rxd), 32'h0);
    mode <= 2'b10;
  endtask
  // scheduled lin master: wait for event, first request, compare load
  task t_sched();
    {sen, afe, run} <= 3'b110;
    wb(1, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 16'h0055);
    wb(1, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 16'h0045);
    wb(0, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 0);
    chk("request held", q, 32'h0055);
    u_sch.pulse();
    wait_fs();
    wb(0, lsc_pkg::OFF_SCHED_COMPARE_LOW, 0);
    chk("compare", q, 32'(16'(cnt + slot)));
    wb(0, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 0);
    chk("request cleared", q, 32'h0045);
    wb(1, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 16'h0035);
    wb(0, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 0);
    chk("first req pending", q, 32'h0035);
    u_sch.pulse();
    wait_fs();
    u_sch.pulse();
    @(posedge clk);
    chk("pending cleared", 32'(pend), 32'h0);
    wb(1, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 16'h0035);
    wait_fs();
    u_sch.pulse();
    {sen, afe, run} <= 3'b001;
  endtask
  task t_len();
    wb(1, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 16'h0011);
    wait_fs();
    chk("bad length", 32'(flags.prep_incomplete_error), 32'h1);
    u_sch.pulse(); // clears pending; outside scheduled mode pending does not hold back a request
    wb(1, lsc_pkg::OFF_STATUS_CLEAR_HIGH, 16'h0100);
    wb(1, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 16'h001a);
    wait_fs();
    chk("max length", 32'(flags.prep_incomplete_error), 32'h0);
    u_sch.pulse();
  endtask
  task t_power();
    wb(1, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 16'h00c5);
    pwr <= 1'b0;
    repeat (2) @(posedge clk);
    pwr <= 1'b1;
    wb(0, lsc_pkg::OFF_TRANSMIT_CONTROL_LOW, 0);
    chk("power off", q, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_clear();
    t_tctl();
    t_sched();
    t_len();
    t_power();
    complete_run();
  end
endmodule
bind lsc_top lsc_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .ADR_I(ADR_I),
  .DAT_I(DAT_I), .DAT_O(DAT_O), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .ACK_O(ACK_O), .POWER_I(POWER_I), .MODE_I(MODE_I), .AUTO_CHECKSUM_I(AUTO_CHECKSUM_I),
  .STATUS_SET_I(STATUS_SET_I), .FLAGS_O(FLAGS_O), .FRAME_START_O(FRAME_START_O),
  .PENDING_O(PENDING_O), .ENHANCED_CHECKSUM_O(ENHANCED_CHECKSUM_O),
  .RX_DIRECTION_O(RX_DIRECTION_O), .TCTL_O(TCTL_O));

// file: verilog/lsc_top.sv
// status-clear, scheduler compare and transmit-control logic of the serial controller
`timescale 1ns/1ps
// How it works
// - a one in low clear bits 11..0 clears that rx buffer error flag
// - clear registers take 16-bit writes only; their reads are undefined (zero here)
// - high clear bit 13 clears the tx buffer empty flag
// - high clear bit 12 clears the rx buffer full flag
// - high clear bit 11 clears the rx overflow flag
// - high clear bit 10 clears the checksum error flag
// - high clear bit 9 clears the scheduler ready flag
// - high clear bit 8 clears the preparation incomplete error
// - high clear bit 7 clears the break field error
// - high clear bit 6 clears the sync field error
// - at lin master frame start compare loads free count plus slot length
// - transmit control clears on reset and when power bit is low
// - bit 7 picks classic or enhanced checksum
// - checksum type only matters while auto checksum is on
// - bit 6 picks master tx or rx, only in lin master mode
// - in scheduled mode bit 5 clear waits for scheduler event, set starts at once if idle
// - first request while pending behaves as if clear
// - transmit request self-clears on start; writing zero does nothing
// - lin master request starts a frame even in receive direction
// - lin length outside 2..10 raises preparation incomplete error
module lsc_top #(
  parameter int COUNT_W = 16
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic [3:0] SEL_I,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic ACK_O,
  input wire logic POWER_I,
  input wire logic [1:0] MODE_I,
  input wire logic AUTO_CHECKSUM_I,
  input wire logic SCHED_ENABLE_I,
  input wire logic AUTO_FRAME_I,
  input wire logic SCHED_EVENT_I,
  input wire logic [COUNT_W-1:0] FREE_COUNT_I,
  input wire logic [COUNT_W-1:0] SLOT_LENGTH_I,
  input wire logic [11:0] RX_ERR_SET_I,
  input wire logic [7:0] STATUS_SET_I,
  output lsc_pkg::lsc_flags_type FLAGS_O,
  output logic FRAME_START_O,
  output logic PENDING_O,
  output logic ENHANCED_CHECKSUM_O,
  output logic RX_DIRECTION_O,
  output lsc_pkg::lsc_tctl_type TCTL_O
);

  // ==========================================
  // bus decode
  wire logic req = CYC_I & STB_I & ~ACK_O;
  wire logic half_low = SEL_I[0] & SEL_I[1];
  // a write lands at the edge where the master samples ack, not at the request edge
  wire logic wr = CYC_I & STB_I & ACK_O & WE_I & half_low;
  wire logic hit_cll = ADR_I == lsc_pkg::OFF_RX_ERROR_CLEAR_LOW;
  wire logic hit_clh = ADR_I == lsc_pkg::OFF_STATUS_CLEAR_HIGH;
  wire logic hit_cmpl = ADR_I == lsc_pkg::OFF_SCHED_COMPARE_LOW;
  wire logic hit_cmph = ADR_I == lsc_pkg::OFF_SCHED_COMPARE_HIGH;
  wire logic hit_tctl = ADR_I == lsc_pkg::OFF_TRANSMIT_CONTROL_LOW;
  // byte-only writes are dropped since the registers take halfwords
  wire logic wr_cll = wr & hit_cll;
  wire logic wr_clh = wr & hit_clh;
  wire logic wr_tctl = wr & hit_tctl;

  // ==========================================
  // state
  logic [11:0] rxbe_r;
  logic [7:0] stat_r;
  logic [15:0] cmp_r;
  logic [7:0] tctl_r;
  logic pending_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic frame_start_r;
  logic [7:0] tctl_nxt;
  logic [15:0] cmp_nxt;
  logic [11:0] rxbe_nxt;
  logic [7:0] stat_nxt;
  logic pending_nxt;
  logic [31:0] dat_nxt;

  // ==========================================
  // mode qualifiers
  wire logic lin_master = MODE_I == lsc_pkg::MODE_LIN_MASTER;
  wire logic through_mode = MODE_I == lsc_pkg::MODE_UART_THROUGH;
  wire logic scheduled = lin_master & SCHED_ENABLE_I & AUTO_FRAME_I;
  wire logic trq = tctl_r[lsc_pkg::BIT_TRQ];
  wire logic frq = tctl_r[lsc_pkg::BIT_FRQ];
  wire logic [3:0] tlg = tctl_r[3:0];
  // through mode never starts a frame; software keeps the request low there
  wire logic req_live = trq & ~through_mode;
  // in scheduled mode immediate start only with no frame pending, else wait for the event
  wire logic go_now = frq & scheduled & ~pending_r;
  wire logic go_event = SCHED_EVENT_I | ~scheduled;
  // direction does not gate the start in lin master mode
  // no start while power is off, so a start never outlives the forced clear
  wire logic start = req_live & POWER_I & (go_now | go_event);
  wire logic len_bad = lin_master & ((tlg < lsc_pkg::LIN_LEN_MIN) | (tlg > lsc_pkg::LIN_LEN_MAX));
  wire logic prep_err = start & len_bad;
  wire logic [COUNT_W-1:0] cmp_sum = FREE_COUNT_I + SLOT_LENGTH_I;

  // ==========================================
  // next state of flags: set wins over a clear in the same cycle
  always_comb begin
    rxbe_nxt = rxbe_r;
    stat_nxt = stat_r;
    if (wr_cll) begin
      rxbe_nxt = rxbe_r & ~DAT_I[lsc_pkg::RXBE_WIDTH-1:0];
    end
    if (wr_clh) begin
      stat_nxt = stat_r & ~DAT_I[lsc_pkg::BIT_CLR_TXEF:lsc_pkg::BIT_CLR_SFE];
    end
    rxbe_nxt = rxbe_nxt | RX_ERR_SET_I;
    stat_nxt = stat_nxt | STATUS_SET_I;
    stat_nxt[lsc_pkg::BIT_CLR_PIE-lsc_pkg::BIT_CLR_SFE] =
      stat_nxt[lsc_pkg::BIT_CLR_PIE-lsc_pkg::BIT_CLR_SFE] | prep_err;
  end

  // transmit control next value
  always_comb begin
    tctl_nxt = tctl_r;
    if (wr_tctl) begin
      tctl_nxt[7:5] = DAT_I[7:5];
      tctl_nxt[3:0] = DAT_I[3:0];
      tctl_nxt[lsc_pkg::BIT_TRQ] = trq | DAT_I[lsc_pkg::BIT_TRQ];
    end
    if (start) begin
      tctl_nxt[lsc_pkg::BIT_TRQ] = 1'b0;
    end
    if (!POWER_I) begin
      tctl_nxt = lsc_pkg::TCTL_RESET;
    end
  end

  // pending frame tracks start until the engine-side event clears it
  always_comb begin
    pending_nxt = pending_r;
    if (SCHED_EVENT_I & pending_r) begin
      pending_nxt = 1'b0;
    end
    if (start) begin
      pending_nxt = 1'b1;
    end
    if (!POWER_I) begin
      pending_nxt = 1'b0;
    end
  end

  // compare loads on lin master frame start only
  always_comb begin
    cmp_nxt = cmp_r;
    if (start & lin_master) begin
      cmp_nxt = 16'(cmp_sum);
    end
  end

  // read mux; clear registers read zero as their value is undefined
  always_comb begin
    dat_nxt = lsc_pkg::UNMAPPED_READ;
    if (hit_cmpl) begin
      dat_nxt = {16'h0000, cmp_r};
    end else if (hit_cmph) begin
      dat_nxt = {16'h0000, lsc_pkg::CMP_HIGH_VALUE};
    end else if (hit_tctl) begin
      dat_nxt = {24'h000000, tctl_r};
    end else if (hit_cll | hit_clh) begin
      dat_nxt = lsc_pkg::UNMAPPED_READ;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      rxbe_r <= 12'h000;
      stat_r <= 8'h00;
      cmp_r <= lsc_pkg::CMP_RESET;
      tctl_r <= lsc_pkg::TCTL_RESET;
      pending_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      frame_start_r <= 1'b0;
    end else begin
      rxbe_r <= rxbe_nxt;
      stat_r <= stat_nxt;
      cmp_r <= cmp_nxt;
      tctl_r <= tctl_nxt;
      pending_r <= pending_nxt;
      ack_r <= req;
      dat_r <= dat_nxt;
      frame_start_r <= start;
    end
  end

  // ==========================================
  // outputs
  assign ACK_O = ack_r;
  assign DAT_O = dat_r;
  assign FRAME_START_O = frame_start_r;
  assign PENDING_O = pending_r;
  // checksum type matters only with auto checksum on
  assign ENHANCED_CHECKSUM_O = tctl_r[lsc_pkg::BIT_SLEC] & AUTO_CHECKSUM_I;
  // direction honoured only in lin master mode
  assign RX_DIRECTION_O = tctl_r[lsc_pkg::BIT_SLRT] & lin_master;
  assign TCTL_O = tctl_r;
  assign FLAGS_O = {rxbe_r, stat_r};

endmodule
